// >>> logic/ussl_top.sv
// synchronous slave serial port: registers, shift paths, receive fifo
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps

// register map at a glance
//   0x0C flags: bit 5 receive word waiting, bit 4 holding empty
//   0x18 receive control: port on, nine-bit, single, continuous,
//        address detect, framing (always 0), overrun, ninth bit
//   0x19 holding register, write only, reads back zero
//   0x1A receive fifo head, a read pops it
//   0x8C wake enables, bit 3 unused
//   0x98 transmit control: clock master, nine-bit, enable, sync,
//        high baud, shift empty, ninth bit
//   0x99 divisor, stored only since the clock comes from outside
// reset
//   the external reset is asynchronous; its release is taken through
//   two flops and every other flop uses that copy, so the first bus
//   access should wait for the third clock after release
// link timing
//   both pins pass two flops, so every falling edge of the shift clock
//   is seen about three system clocks late; the shift clock must stay
//   low and high for at least three system clocks each
//   transmit bits change about four system clocks after a falling
//   edge, so the master samples the current bit on that falling edge
//   receive bits are taken from the synchronised data pin in the
//   cycle in which the falling edge is detected
//   nothing here runs on the shift clock itself, which keeps a single
//   clock domain at the price of a minimum link period
// hazards and limits
//   dropping the transmit enable abandons the word in flight and
//   empties the holding register; nothing is resent
//   turning on continuous receive takes the data pin from transmit
//   after an overrun the receiver stays blocked until continuous
//   receive is dropped and raised again
//   a read of the fifo while empty returns the stale head and does
//   not move the pointers
//   the ninth received bit follows the fifo head, so it must be read
//   before the data word that pops it
//   a new overrun wins over a clear in the same cycle
//   global interrupt enable and the sleep state live in the core;
//   this block only raises a level wake request

// Contract
// - slave transmit behaves like master transmit
// - holding write into empty shifter starts immediately
// - second word waits, transmit flag stays clear
// - after shift-out, load second word, set flag
// - transmit flag with enable raises wake request
// - writing holding register starts a transmission
// - single-receive enable ignored in slave mode
// - continuous receive keeps working during core sleep
// - full word moves into fifo, may wake
// - receive flag set; wake only when enabled
// - clearing continuous receive clears pending error
// - incoming bits sampled on shift clock falling edge
// - receive data register is two-entry fifo
// - overrun sets flag, drops word, blocks transfers
module ussl_top
  import ussl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial link pins
  input wire logic shift_clk_in,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  // wake request toward the core
  output logic wake_req
);

  // synchronisers for reset and link pins
  logic rst_meta_ff, rst_sync_ff;
  logic ck_meta_ff, ck_sync_ff, ck_prev_ff;
  logic dt_meta_ff, dt_sync_ff;
  // software-visible control
  logic [7:0] rx_ctl_ff, tx_ctl_ff, irq_en_ff, baud_div_ff;
  // transmit holding and shift state
  logic [7:0] tx_holding_reg_ff;
  logic tx_full_ff;
  logic [8:0] tx_shift_reg_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_shift_empty_ff;
  // receive shift state and two-entry fifo
  logic [8:0] rx_shift_reg_ff;
  logic [3:0] rx_cnt_ff;
  logic [8:0] rx_mem_ff [2];
  logic rx_rd_ptr_ff, rx_wr_ptr_ff;
  logic [1:0] rx_count_ff;
  logic overrun_error_ff;
  // read data and combinational glue
  logic [7:0] rdata_ff;
  logic fall_edge, slave_mode, tx_on, rx_on;
  logic tx_load, tx_done, rx_done, rx_push, rx_pop;
  logic [3:0] tx_bits, rx_bits;
  logic [8:0] nxt_rx_shift, rx_word;
  logic tx_empty_flag, rx_full_flag;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // link pins come from another domain; the first flop is never read
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ck_meta_ff <= 1'b0;
      ck_sync_ff <= 1'b0;
      ck_prev_ff <= 1'b0;
      dt_meta_ff <= 1'b0;
      dt_sync_ff <= 1'b0;
    end else begin
      ck_meta_ff <= shift_clk_in;
      ck_sync_ff <= ck_meta_ff;
      ck_prev_ff <= ck_sync_ff;
      dt_meta_ff <= data_pin_in;
      dt_sync_ff <= dt_meta_ff;
    end
  end

  // shift clock is never driven here, only observed
  assign fall_edge = ck_prev_ff & ~ck_sync_ff;

  // slave mode: port on, synchronous, clock from outside
  assign slave_mode = rx_ctl_ff[BIT_PORT_EN] & tx_ctl_ff[BIT_SYNC]
                      & ~tx_ctl_ff[BIT_CLK_MASTER];
  // single-receive bit plays no part in slave mode
  assign rx_on = slave_mode & rx_ctl_ff[BIT_CONT_RX];
  // receive owns the shared data pin when both are on
  assign tx_on = slave_mode & tx_ctl_ff[BIT_TX_ENABLE]
                 & ~rx_ctl_ff[BIT_CONT_RX];
  assign tx_bits = tx_ctl_ff[BIT_TX_NINE_SEL] ? WORD_BITS_9 : WORD_BITS_8;
  assign rx_bits = rx_ctl_ff[BIT_RX_NINE_SEL] ? WORD_BITS_9 : WORD_BITS_8;

  // control register writes; status bits are owned by hardware
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rx_ctl_ff <= RX_STATUS_RESET;
      tx_ctl_ff <= TX_STATUS_RESET;
      irq_en_ff <= IRQ_ENABLES_RESET;
      baud_div_ff <= BAUD_DIV_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_RX_STATUS: begin
          rx_ctl_ff <= reg_wdata & RX_STATUS_WMASK;
        end
        ADDR_TX_STATUS: begin
          tx_ctl_ff <= reg_wdata & TX_STATUS_WMASK;
        end
        ADDR_IRQ_ENABLES: begin
          irq_en_ff <= reg_wdata & IRQ_ENABLES_WMASK;
        end
        ADDR_BAUD_DIV: begin
          baud_div_ff <= reg_wdata;
        end
        default: begin
          baud_div_ff <= baud_div_ff;
        end
      endcase
    end
  end

  // holding register write starts a transfer; a load empties it
  assign tx_load = tx_full_ff & tx_shift_empty_ff & tx_on;
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tx_holding_reg_ff <= TX_HOLD_RESET;
      tx_full_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_TX_HOLD) begin
        tx_holding_reg_ff <= reg_wdata;
        tx_full_ff <= 1'b1;
      end else if (tx_load || !tx_ctl_ff[BIT_TX_ENABLE]) begin
        tx_full_ff <= 1'b0;
      end
    end
  end

  // flag follows the holding register: set once its word moved on
  assign tx_empty_flag = tx_ctl_ff[BIT_TX_ENABLE] & ~tx_full_ff;

  // tx shifter: each falling edge the master takes one bit, lsb first
  assign tx_done = ~tx_shift_empty_ff & fall_edge
                   & (tx_cnt_ff == tx_bits - 4'h1);
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tx_shift_reg_ff <= 9'h000;
      tx_cnt_ff <= 4'h0;
      tx_shift_empty_ff <= 1'b1;
    end else if (!tx_on) begin
      // dropping the enable abandons the word in flight
      tx_cnt_ff <= 4'h0;
      tx_shift_empty_ff <= 1'b1;
    end else if (tx_load) begin
      // ninth bit is taken as it stands at load time
      tx_shift_reg_ff <= {tx_ctl_ff[BIT_TX_NINTH], tx_holding_reg_ff};
      tx_cnt_ff <= 4'h0;
      tx_shift_empty_ff <= 1'b0;
    end else if (tx_done) begin
      tx_cnt_ff <= 4'h0;
      tx_shift_empty_ff <= 1'b1;
    end else if (!tx_shift_empty_ff && fall_edge) begin
      tx_shift_reg_ff <= {1'b0, tx_shift_reg_ff[8:1]};
      tx_cnt_ff <= tx_cnt_ff + 4'h1;
    end
  end

  // transmit path runs in slave mode only; with the clock-master bit set the pin is not driven
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      data_pin_out <= 1'b0;
      data_pin_oe <= 1'b0;
    end else begin
      data_pin_out <= tx_shift_reg_ff[0];
      data_pin_oe <= tx_on;
    end
  end

  // rx shifter fills from the top so the lsb lands at bit 0
  assign nxt_rx_shift = {dt_sync_ff, rx_shift_reg_ff[8:1]};
  assign rx_word = rx_ctl_ff[BIT_RX_NINE_SEL] ? nxt_rx_shift
                   : {1'b0, nxt_rx_shift[8:1]};
  // overrun stops the receive shifter until the enable is dropped
  assign rx_done = rx_on & ~overrun_error_ff & fall_edge
                   & (rx_cnt_ff == rx_bits - 4'h1);
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rx_shift_reg_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
    end else if (!rx_on || overrun_error_ff) begin
      rx_cnt_ff <= 4'h0;
    end else if (fall_edge) begin
      rx_shift_reg_ff <= nxt_rx_shift;
      rx_cnt_ff <= rx_done ? 4'h0 : rx_cnt_ff + 4'h1;
    end
  end

  // two-entry fifo; a word finishing with both full is lost
  assign rx_pop = reg_rd & (reg_addr == ADDR_RX_FIFO) & (rx_count_ff != 2'h0);
  assign rx_push = rx_done & (rx_count_ff != FIFO_DEPTH);
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rx_mem_ff[0] <= 9'h000;
      rx_mem_ff[1] <= 9'h000;
      rx_wr_ptr_ff <= 1'b0;
      rx_rd_ptr_ff <= 1'b0;
      rx_count_ff <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_mem_ff[rx_wr_ptr_ff] <= rx_word;
        rx_wr_ptr_ff <= ~rx_wr_ptr_ff;
      end
      if (rx_pop) begin
        rx_rd_ptr_ff <= ~rx_rd_ptr_ff;
      end
      if (rx_push && !rx_pop) begin
        rx_count_ff <= rx_count_ff + 2'h1;
      end else if (rx_pop && !rx_push) begin
        rx_count_ff <= rx_count_ff - 2'h1;
      end
    end
  end

  // overrun flag; a new overrun beats the clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      overrun_error_ff <= 1'b0;
    end else if (rx_done && rx_count_ff == FIFO_DEPTH) begin
      overrun_error_ff <= 1'b1;
    end else if (!rx_ctl_ff[BIT_CONT_RX]) begin
      overrun_error_ff <= 1'b0;
    end
  end

  assign rx_full_flag = rx_count_ff != 2'h0;

  // wake request: the core decides about global interrupts
  assign wake_req = (tx_empty_flag & irq_en_ff[BIT_TX_EMPTY])
                    | (rx_full_flag & irq_en_ff[BIT_RX_FULL]);

  // read data stands the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_IRQ_FLAGS: begin
          rdata_ff <= 8'h00;
          rdata_ff[BIT_RX_FULL] <= rx_full_flag;
          rdata_ff[BIT_TX_EMPTY] <= tx_empty_flag;
        end
        ADDR_RX_STATUS: begin
          // framing errors cannot occur in synchronous mode
          rdata_ff <= rx_ctl_ff;
          rdata_ff[BIT_OVERRUN] <= overrun_error_ff;
          rdata_ff[BIT_RX_NINTH] <= rx_mem_ff[rx_rd_ptr_ff][8];
        end
        ADDR_RX_FIFO: begin
          rdata_ff <= rx_mem_ff[rx_rd_ptr_ff][7:0];
        end
        ADDR_IRQ_ENABLES: begin
          rdata_ff <= irq_en_ff;
        end
        ADDR_TX_STATUS: begin
          rdata_ff <= tx_ctl_ff;
          rdata_ff[BIT_SHIFT_EMPTY] <= tx_shift_empty_ff;
        end
        ADDR_BAUD_DIV: begin
          rdata_ff <= baud_div_ff;
        end
        default: begin
          rdata_ff <= 8'h00; // holding register and holes read zero
        end
      endcase
    end
  end
  assign reg_rdata = rdata_ff;

endmodule

// >>> logic/ussl_pkg.sv
// constants for the synchronous slave serial port
package ussl_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h19;
  localparam logic [7:0] ADDR_RX_FIFO = 8'h1A;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h99;
  // flag and enable bit positions
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_TX_EMPTY = 4;
  // receive status/control bit positions
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_RX_NINE_SEL = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX = 4;
  localparam int BIT_ADDR_DETECT = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_NINTH = 0;
  // transmit status/control bit positions
  localparam int BIT_CLK_MASTER = 7;
  localparam int BIT_TX_NINE_SEL = 6;
  localparam int BIT_TX_ENABLE = 5;
  localparam int BIT_SYNC = 4;
  localparam int BIT_HIGH_BAUD = 2;
  localparam int BIT_SHIFT_EMPTY = 1;
  localparam int BIT_TX_NINTH = 0;
  // writable masks and reset values
  localparam logic [7:0] RX_STATUS_WMASK = 8'hF8;
  localparam logic [7:0] TX_STATUS_WMASK = 8'hF5;
  localparam logic [7:0] IRQ_ENABLES_WMASK = 8'hF7;
  localparam logic [7:0] RX_STATUS_RESET = 8'h00;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [7:0] IRQ_ENABLES_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIV_RESET = 8'h00;
  localparam logic [7:0] TX_HOLD_RESET = 8'h00;
  // word lengths in bits and fifo depth in entries
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

// >>> testbench/ussl_top_asserts.sv
// checker for the synchronous slave serial port
`timescale 1ns/100ps
module ussl_top_asserts
  import ussl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // link pins and wake
  input wire logic shift_clk_in,
  input wire logic data_pin_in,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // read data only moves after a read strobe
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_txhold_zero: assert property (reg_rd && reg_addr == ADDR_TX_HOLD
    |=> reg_rdata == 8'h00) else $error("holding register read not zero");
  a_flags_unused: assert property (reg_rd && reg_addr == ADDR_IRQ_FLAGS
    |=> reg_rdata[3:0] == 4'h0 && reg_rdata[7:6] == 2'h0)
    else $error("unused flag bits set");
  a_framing_error_zero: assert property (reg_rd && reg_addr == ADDR_RX_STATUS
    |=> !reg_rdata[BIT_FRAME_ERR]) else $error("framing error bit set");
  a_wake_off: assert property (reg_wr && reg_addr == ADDR_IRQ_ENABLES
    && reg_wdata[5:4] == 2'b00 |=> !wake_req) else $error("wake while masked");
  // a receive enable or a transmit disable must free the data pin
  a_continuous_receive_enable_oe: assert property (reg_wr && reg_addr == ADDR_RX_STATUS
    && reg_wdata[BIT_CONT_RX] |-> ##[1:4] !data_pin_oe)
    else $error("pin still driven while receiving");
  a_transmitter_enable_oe: assert property (reg_wr && reg_addr == ADDR_TX_STATUS
    && !reg_wdata[BIT_TX_ENABLE] |-> ##[1:4] !data_pin_oe)
    else $error("pin still driven with transmitter off");
  a_baud_back: assert property (reg_wr && reg_addr == ADDR_BAUD_DIV ##2
    reg_rd && reg_addr == ADDR_BAUD_DIV |=> reg_rdata == $past(reg_wdata, 3))
    else $error("divisor readback wrong");
endmodule
bind ussl_top ussl_top_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_clk_in(shift_clk_in),
  .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe), .wake_req(wake_req));

// >>> testbench/ussl_master_model.sv
// far-end master that clocks the slave port
`timescale 1ns/100ps
module ussl_master_model (
  // link pins seen from the master
  output logic sclk,
  output logic sdata,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
  end
  // one word lsb first; clock idles high, so it stands still between frames
  task automatic xfer(input int n, input logic [8:0] w,
                      output logic [8:0] r);
    r = 9'h000;
    #3;
    for (int i = 0; i < n; i++) begin
      sdata = w[i];
      #62.5 sclk = 1'b0;
      r[i] = dout;
      #62.5 sclk = 1'b1;
    end
    sdata = ~sdata; // released line must not keep the last bit
  endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the synchronous slave serial port
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import ussl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic sclk, sdin, dout, doe, wake, ovr = 1'b0;
  logic [31:0] seed = 32'h81619BE9;
  logic [8:0] r, w;
  logic [8:0] fifo[$];
  logic [7:0] ra[8] = '{8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h55};
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  int err_count = 0, total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  ussl_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shift_clk_in(sclk), .data_pin_in(sdin),
    .data_pin_out(dout), .data_pin_oe(doe), .wake_req(wake));
  ussl_master_model master (.sclk(sclk), .sdata(sdin),
    .dout(dout));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bus tasks start just after a rising edge and leave one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata & m;
    `CHK(d, e)
    @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (ra[i]) rd(ra[i], 8'hFF, rv[i]);
    $display("test reset done");
    seed = lfsr(seed);
    wr(ADDR_BAUD_DIV, seed[7:0]);
    rd(ADDR_BAUD_DIV, 8'hFF, seed[7:0]);
    wr(ADDR_IRQ_ENABLES, seed[15:8] & 8'hCF);
    rd(ADDR_IRQ_ENABLES, 8'hFF, seed[15:8] & 8'hC7);
    `CHK(wake, 1'b0)
    $display("test registers done");
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_IRQ_ENABLES, 8'h10);
    // with the clock-master bit set the slave must keep off the pin
    wr(ADDR_TX_STATUS, 8'hB0);
    rd(ADDR_TX_STATUS, 8'h80, 8'h80);
    `CHK(doe, 1'b0)
    wr(ADDR_TX_STATUS, 8'h30);
    rd(ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    `CHK(wake, 1'b1)
    `CHK(doe, 1'b1)
    seed = lfsr(seed);
    wr(ADDR_TX_HOLD, seed[7:0]);
    wr(ADDR_TX_HOLD, seed[15:8]);
    rd(ADDR_IRQ_FLAGS, 8'h10, 8'h00);
    rd(ADDR_TX_STATUS, 8'h02, 8'h00);
    master.xfer(8, 9'h000, r);
    `CHK(r[7:0], seed[7:0])
    @(posedge ref_clk);
    rd(ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    rd(ADDR_TX_STATUS, 8'h02, 8'h00);
    master.xfer(8, 9'h000, r);
    `CHK(r[7:0], seed[15:8])
    @(posedge ref_clk);
    rd(ADDR_TX_STATUS, 8'h02, 8'h02);
    wr(ADDR_TX_STATUS, 8'h71);
    wr(ADDR_TX_HOLD, seed[23:16]);
    master.xfer(9, 9'h000, r);
    `CHK(r, {1'b1, seed[23:16]})
    @(posedge ref_clk);
    $display("test transmit done");
    wr(ADDR_TX_STATUS, 8'h10);
    wr(ADDR_IRQ_ENABLES, 8'h20);
    wr(ADDR_RX_STATUS, 8'hA0);
    master.xfer(8, 9'h0A5, r);
    @(posedge ref_clk);
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    wr(ADDR_RX_STATUS, 8'hB0);
    // third word finds the fifo full and is lost
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      master.xfer(8, {1'b0, seed[7:0]}, r);
      if (fifo.size() < FIFO_DEPTH) fifo.push_back({1'b0, seed[7:0]});
      else ovr = 1'b1;
      @(posedge ref_clk);
    end
    rd(ADDR_RX_STATUS, 8'h02, {6'h00, ovr, 1'b0});
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h20);
    `CHK(wake, 1'b1)
    while (fifo.size() > 0) begin
      w = fifo.pop_front();
      rd(ADDR_RX_FIFO, 8'hFF, w[7:0]);
    end
    rd(ADDR_IRQ_FLAGS, 8'h20, 8'h00);
    wr(ADDR_RX_STATUS, 8'hC0);
    rd(ADDR_RX_STATUS, 8'h02, 8'h00);
    wr(ADDR_RX_STATUS, 8'hD0);
    master.xfer(9, {1'b1, seed[15:8]}, r);
    @(posedge ref_clk);
    rd(ADDR_RX_STATUS, 8'h01, 8'h01);
    rd(ADDR_RX_FIFO, 8'hFF, seed[15:8]);
    $display("test receive done");
    give_verdict();
  end
  // watchdog: the tests need well under this span
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
